// [adc_seq_map.vh]
// adc_seq_map.vh: constants for the conversion and sleep sequencer
// assumes inclusion by the sequencer and its timer, definitions only
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH
// interval lengths in 4 ns cycles: 2800 ns conversion, 200 us calibration
`define CONV_CYCLES 16'h02bc
`define CAL_CYCLES 16'hc350
`define CNT_W 16
// state codes
`define ST_IDLE 2'h0
`define ST_CONV 2'h1
`define ST_CAL 2'h2
`define ST_SLEEP 2'h3
`endif

// [adc_seq_timer.v]
// adc_seq_timer.v: down counter that times one conversion or calibration
// assumes load and abort come from the sequencer on the same clock
`timescale 1ns/1ps
`include "adc_seq_map.vh"
module adc_seq_timer #(
	parameter CNT_W = `CNT_W
) (
	input wire clk_in, // system clock
	input wire nrst_in, // synchronous reset, active low
	input wire load_in, // start a new timed interval
	input wire [CNT_W-1:0] count_in, // interval length in cycles
	input wire abort_in, // stop the interval at once
	output reg done_out // one-cycle pulse at interval end
);
	reg [CNT_W-1:0] remain;
	reg running;
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			remain <= {CNT_W{1'b0}};
			running <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (abort_in) begin
				running <= 1'b0;
			end else if (load_in) begin
				remain <= count_in;
				running <= 1'b1;
			end else if (running) begin
				if (remain <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
					running <= 1'b0;
					done_out <= 1'b1;
				end else begin
					remain <= remain - {{(CNT_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // adc_seq_timer

// [adc_conversion_sleep_control.v]
// adc_conversion_sleep_control.v: conversion, calibration and sleep sequencer
// assumes the three control inputs are asynchronous pins; everything else runs on clk_in
// Operation
// - a rising edge of conversion_trigger places the track-and-hold in hold and starts a conversion.
// - busy rises on the falling edge of conversion_trigger or the rising edge of calibration request and stays high until done.
// - busy is also high for the whole calibration and falls when calibration completes.
// - sleep low powers down all circuitry and the reference, but only while nothing is in progress and calibration request is high.
// - calibration coefficients are kept through sleep so no recalibration is needed on wake.
// - sleep high keeps conversion and calibration circuitry powered for normal operation.
// - at the end of each conversion the track-and-hold goes back to track mode.
// - calibration request low resets calibration control and its rising edge starts a calibration that overrides all else but a sleep exit in the same cycle.
`timescale 1ns/1ps
`include "adc_seq_map.vh"
module adc_conversion_sleep_control #(
	parameter CNT_W = `CNT_W,
	parameter [CNT_W-1:0] CONV_CYCLES = `CONV_CYCLES,
	parameter [CNT_W-1:0] CAL_CYCLES = `CAL_CYCLES
) (
	input wire clk_in, // system clock, 250 MHz
	input wire nrst_in, // synchronous reset, active low
	input wire conversion_trigger_in, // convert start pin
	input wire cal_req_in, // calibration request pin, low resets calibration
	input wire sleep_n_in, // sleep pin, low requests power-down
	output reg busy_out, // conversion or calibration in progress
	output reg hold_out, // track-and-hold in hold mode
	output reg power_on_out, // analog circuitry and reference powered
	output reg cal_valid_out, // stored calibration coefficients valid
	output reg cal_reset_out // calibration control held in reset
);
	reg [1:0] conv_s;
	reg [1:0] cal_s;
	reg [1:0] sleep_s;
	reg conv_q;
	reg cal_q;
	reg [1:0] state;
	reg [1:0] next_state;
	reg load;
	reg abort;
	reg [CNT_W-1:0] load_count;
	reg next_busy;
	reg next_hold;
	reg next_power;
	reg next_cal_valid;
	wire done;
	wire conv_rise;
	wire conv_fall;
	wire cal_rise;
	wire cal_low;
	wire sleep_req;

	// two-stage synchronisers; edges taken from the second stage only
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			conv_s <= 2'h3;
			conv_q <= 1'b1;
		end else begin
			conv_s <= {conv_s[0], conversion_trigger_in};
			conv_q <= conv_s[1];
		end
	end

	always @(posedge clk_in) begin
		if (!nrst_in) begin
			cal_s <= 2'h3;
			cal_q <= 1'b1;
		end else begin
			cal_s <= {cal_s[0], cal_req_in};
			cal_q <= cal_s[1];
		end
	end

	always @(posedge clk_in) begin
		if (!nrst_in) begin
			sleep_s <= 2'h3;
		end else begin
			sleep_s <= {sleep_s[0], sleep_n_in};
		end
	end

	// rising edge of a synchronised pin against its previous sample
	function edge_up;
		input cur;
		input prev;
		begin
			edge_up = cur & ~prev;
		end
	endfunction

	// the converter is occupied while a conversion or calibration runs
	function is_active;
		input [1:0] s;
		begin
			is_active = (s == `ST_CONV) || (s == `ST_CAL);
		end
	endfunction

	// interval length for the timer: calibration or conversion
	function [CNT_W-1:0] interval;
		input cal;
		begin
			interval = cal ? CAL_CYCLES : CONV_CYCLES;
		end
	endfunction

	assign conv_rise = edge_up(conv_s[1], conv_q);
	assign conv_fall = ~conv_s[1] & conv_q;
	assign cal_rise = edge_up(cal_s[1], cal_q);
	assign cal_low = ~cal_s[1];
	assign sleep_req = ~sleep_s[1];

	// one timer serves both intervals; an abort frees it for a calibration restart
	adc_seq_timer #(
		.CNT_W(CNT_W)
	) u_timer (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.load_in(load),
		.count_in(load_count),
		.abort_in(abort),
		.done_out(done)
	);

	always @* begin
		next_state = state;
		load = 1'b0;
		abort = 1'b0;
		load_count = interval(1'b0);
		// cal low aborts whatever runs; a calibration edge wins over every other start
		case (state)
		`ST_IDLE: begin
			if (cal_rise) begin
				next_state = `ST_CAL;
				load = 1'b1;
				load_count = interval(1'b1);
			end else if (conv_rise) begin
				next_state = `ST_CONV;
				load = 1'b1;
			end else if (sleep_req && !busy_out && !conv_fall && !cal_low) begin
				next_state = `ST_SLEEP;
			end
		end
		`ST_CONV: begin
			if (cal_rise) begin
				next_state = `ST_CAL;
				load = 1'b1;
				load_count = interval(1'b1);
			end else if (cal_low) begin
				next_state = `ST_IDLE;
				abort = 1'b1;
			end else if (done) begin
				next_state = `ST_IDLE;
			end
		end
		`ST_CAL: begin
			if (cal_low) begin
				next_state = `ST_IDLE;
				abort = 1'b1;
			end else if (done) begin
				next_state = `ST_IDLE;
			end
		end
		`ST_SLEEP: begin
			if (!sleep_req) begin
				next_state = `ST_IDLE;
			// trigger edges are ignored while powered down
			end else if (cal_rise) begin
				next_state = `ST_CAL;
				load = 1'b1;
				load_count = interval(1'b1);
			end
		end
		default: begin
			next_state = `ST_IDLE;
		end
		endcase
	end

	// output next values; every output is then taken straight from a register
	always @* begin
		next_hold = (next_state == `ST_CONV);
		next_power = (next_state != `ST_SLEEP);
		next_busy = busy_out;
		next_cal_valid = cal_valid_out;
		// a trigger fall marks the converter busy before its rise starts the conversion
		if (conv_fall && state != `ST_SLEEP) begin
			next_busy = 1'b1;
		end else if (is_active(next_state)) begin
			next_busy = 1'b1;
		end else if (state != next_state && next_state == `ST_IDLE) begin
			next_busy = 1'b0;
		end
		// sleep entry and exit leave the coefficients untouched
		if (state == `ST_CAL && done && !cal_low) begin
			next_cal_valid = 1'b1;
		end else if (cal_low) begin
			next_cal_valid = 1'b0;
		end
	end

	always @(posedge clk_in) begin
		if (!nrst_in) begin
			state <= `ST_IDLE;
			busy_out <= 1'b0;
			hold_out <= 1'b0;
			power_on_out <= 1'b1;
			cal_valid_out <= 1'b0;
			cal_reset_out <= 1'b0;
		end else begin
			state <= next_state;
			busy_out <= next_busy;
			hold_out <= next_hold;
			power_on_out <= next_power;
			cal_valid_out <= next_cal_valid;
			cal_reset_out <= cal_low;
		end
	end
endmodule // adc_conversion_sleep_control

// [adc_seq_chk.sv]
// adc_seq_chk.sv: assertions on the sequencer ports
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
module adc_seq_chk (
	input wire clk_in, nrst_in, conversion_trigger_in, cal_req_in, sleep_n_in,
	input wire busy_out, hold_out, power_on_out, cal_valid_out, cal_reset_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	sequence conv_go;
		$rose(conversion_trigger_in) && !hold_out && power_on_out && sleep_n_in && cal_req_in;
	endsequence
	a_conv_start: assert property (conv_go |-> ##[1:6] hold_out && busy_out) else $error("no hold");
	a_conv_len: assert property ($rose(hold_out) |-> (hold_out && busy_out) [*8]) else $error("short");
	a_end_track: assert property ($fell(hold_out) |-> !busy_out) else $error("hold late");
	a_sleep_idle: assert property ($fell(power_on_out) |-> !$past(busy_out)) else $error("busy sleep");
	a_cal_keep: assert property ($changed(power_on_out) |-> $stable(cal_valid_out)) else $error("cal lost");
	a_wake_up: assert property ($rose(sleep_n_in) |-> ##[1:6] power_on_out) else $error("no wake");
	a_cal_clear: assert property ($fell(cal_req_in) |-> ##[1:6] cal_reset_out && !cal_valid_out) else $error("cal rst");
	a_cal_done: assert property ($rose(cal_valid_out) |-> !busy_out) else $error("cal busy");
endmodule // adc_seq_chk
bind adc_conversion_sleep_control adc_seq_chk u_chk (.*);

// [adc_host_model.sv]
// adc_host_model.sv: host driving trigger, calibration and sleep pins
// assumes the caller passes the system clock
`timescale 1ns/1ps
module adc_host_model (
	input wire clk_in, // system clock
	output reg trig_out, // trigger pin
	output reg cal_n_out, // calibration pin
	output reg sleep_n_out // sleep pin
);
	initial begin
		trig_out = 1'b1;
		cal_n_out = 1'b1;
		sleep_n_out = 1'b1;
	end
	task dr(input logic t, c, s);
		@(negedge clk_in);
		trig_out = t;
		cal_n_out = c;
		sleep_n_out = s;
	endtask
endmodule // adc_host_model

// [adc_conversion_sleep_control_test.sv]
// adc_conversion_sleep_control_test.sv: directed bench for the sequencer
// assumes short conversion and calibration counts
`timescale 1ns/1ps
module adc_conversion_sleep_control_test;
	logic clk_in = 0;
	logic nrst_in = 0;
	wire trg, cal, slp;
	wire [4:0] st;
	int n_mismatch = 0;
	int checks = 0;
	always #2 clk_in = ~clk_in;
	adc_host_model u_host (.clk_in(clk_in), .trig_out(trg), .cal_n_out(cal), .sleep_n_out(slp));
	adc_conversion_sleep_control #(.CONV_CYCLES(16'h000a), .CAL_CYCLES(16'h0028)) u_dut (.clk_in(clk_in),
		.nrst_in(nrst_in), .conversion_trigger_in(trg), .cal_req_in(cal), .sleep_n_in(slp), .busy_out(st[4]),
		.hold_out(st[3]), .power_on_out(st[2]), .cal_valid_out(st[1]), .cal_reset_out(st[0]));
	task chk(input logic [4:0] got, exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task end_sim;
		$display("mismatches=%0d checks=%0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task wt(input logic [4:0] m, v, input int n);
		while (n > 0 && (st & m) !== v) begin
			@(negedge clk_in);
			n--;
		end
		if ((st & m) !== v) begin
			n_mismatch++;
			end_sim;
		end
	endtask
	task w6;
		repeat (6) @(negedge clk_in);
	endtask
	task conv_run;
		u_host.dr(0, 1, 1);
		w6;
		chk(st & 5'h18, 5'h10);
		u_host.dr(1, 1, 1);
		wt(5'h08, 5'h08, 8);
		chk(st & 5'h18, 5'h18);
		wt(5'h18, 5'h00, 20);
		chk(st & 5'h1c, 5'h04);
	endtask
	task cal_run;
		u_host.dr(1, 0, 1);
		w6;
		chk(st & 5'h13, 5'h01);
		u_host.dr(1, 1, 1);
		w6;
		chk(st & 5'h12, 5'h10);
		wt(5'h12, 5'h02, 60);
		chk(st & 5'h13, 5'h02);
	endtask
	task sleep_run;
		u_host.dr(1, 1, 0);
		w6;
		chk(st & 5'h16, 5'h02);
		u_host.dr(1, 1, 1);
		w6;
		chk(st & 5'h16, 5'h06);
	endtask
	task defer_run;
		u_host.dr(0, 1, 1);
		w6;
		u_host.dr(1, 1, 1);
		wt(5'h08, 5'h08, 8);
		u_host.dr(1, 1, 0);
		repeat (3) @(negedge clk_in);
		chk(st & 5'h14, 5'h14);
		wt(5'h10, 5'h00, 20);
		w6;
		chk(st & 5'h06, 5'h02);
		u_host.dr(1, 1, 1);
		w6;
	endtask
	task busy_sleep_run;
		u_host.dr(0, 1, 0);
		w6;
		chk(st & 5'h14, 5'h14);
		u_host.dr(1, 1, 0);
		wt(5'h10, 5'h00, 30);
		w6;
		chk(st & 5'h14, 5'h00);
		u_host.dr(1, 1, 1);
		w6;
	endtask
	initial begin
		repeat (4) @(negedge clk_in);
		chk(st, 5'h04);
		nrst_in = 1;
		conv_run;
		cal_run;
		sleep_run;
		defer_run;
		busy_sleep_run;
		end_sim;
	end
endmodule // adc_conversion_sleep_control_test
